// [hdl/swkcdr_pkg.sv]
package swkcdr_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] ADDR_CTRL_ONE   = 7'h3c;
    localparam logic [6:0] ADDR_CTRL_TWO   = 7'h3d;
    localparam logic [6:0] ADDR_UPPER_LIM  = 7'h3e;
    localparam logic [6:0] ADDR_LOWER_LIM  = 7'h3f;
    localparam logic [6:0] ADDR_FAMILY     = 7'h7e;
    localparam int         STAT_N          = 14;
    localparam logic [6:0] STAT_ADDR [STAT_N] = '{
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47,
        7'h48, 7'h54, 7'h55, 7'h70, 7'h71, 7'h72, 7'h73};

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         CTRL1_EN_POS    = 0;
    localparam int         CTRL1_FILT_POS  = 2;
    localparam int         CTRL2_CLK_POS   = 0;
    localparam logic [7:0] CTRL1_RST       = 8'h04;
    localparam logic [7:0] CTRL2_RST       = 8'h00;
    localparam logic [7:0] UPPER_RST       = 8'ha8;
    localparam logic [7:0] LOWER_RST       = 8'h98;
    localparam logic [7:0] STAT_RST        = 8'h00;
    // arbitrary value, not a real part code
    localparam logic [7:0] FAMILY_ID       = 8'h5a;
    // watchdog failure bits live in the device information status byte
    localparam int         WD_IDX          = 3;
    localparam logic [7:0] WD_MASK         = 8'hc0;

    // ****************************************
    // serial frame
    // ****************************************
    localparam logic [4:0] FRAME_BITS      = 5'd16;
    localparam logic [4:0] DATA_START      = 5'd8;
    localparam int         MODE_POS        = 7;
    localparam int         DATA_POS        = 8;

    // ****************************************
    // filter and clock selection
    // ****************************************
    localparam logic [1:0] FILT_TC8        = 2'h0;
    localparam logic [1:0] FILT_TC16       = 2'h1;
    localparam logic [1:0] FILT_TC32       = 2'h2;
    localparam logic [1:0] FILT_ADAPT      = 2'h3;
    localparam logic [5:0] TC_8            = 6'h08;
    localparam logic [5:0] TC_16           = 6'h10;
    localparam logic [5:0] TC_32           = 6'h20;
    localparam logic [3:0] DIST_MIN        = 4'h2;
    localparam logic [3:0] DIST_TC32_MAX   = 4'h3;
    localparam logic [3:0] DIST_TC16_MAX   = 4'h8;
    localparam logic [3:0] DIST_MAX        = 4'ha;
    localparam logic [6:0] CLK_MHZ_80      = 7'h50;
    localparam logic [6:0] CLK_MHZ_40      = 7'h28;
    localparam logic [6:0] CLK_MHZ_20      = 7'h14;
    localparam logic [6:0] CLK_MHZ_10      = 7'h0a;

    typedef struct packed {
        logic       enable;
        logic [1:0] filt;
        logic [1:0] clk_sel;
        logic [7:0] upper;
        logic [7:0] lower;
    } swkcdr_cfg_s;

endpackage

// [hdl/swkcdr_shaper.sv]
`timescale 1ns/1ns
module swkcdr_shaper
    import swkcdr_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // configuration
    input  wire swkcdr_cfg_s cfg,
    // recovery datapath
    input  wire logic        edge_valid,
    input  wire logic [3:0]  edge_dist,
    input  wire logic [7:0]  bit_time_in,
    output logic      [5:0]  time_const,
    output logic      [6:0]  clk_mhz,
    output logic      [7:0]  bit_time_out
);

    // ****************************************
    // time constant
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            time_const <= TC_16;
        end else begin
            unique case (cfg.filt)
                FILT_TC8:  time_const <= TC_8;
                FILT_TC16: time_const <= TC_16;
                FILT_TC32: time_const <= TC_32;
                FILT_ADAPT: begin
                    // distances outside 2..10 bits keep the last choice
                    if (edge_valid && edge_dist >= DIST_MIN && edge_dist <= DIST_MAX) begin
                        if (edge_dist <= DIST_TC32_MAX) begin
                            time_const <= TC_32;
                        end else if (edge_dist <= DIST_TC16_MAX) begin
                            time_const <= TC_16;
                        end else begin
                            time_const <= TC_8;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // recovery input clock
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_mhz <= CLK_MHZ_80;
        end else begin
            unique case (cfg.clk_sel)
                2'h0: clk_mhz <= CLK_MHZ_80;
                2'h1: clk_mhz <= CLK_MHZ_40;
                2'h2: clk_mhz <= CLK_MHZ_20;
                2'h3: clk_mhz <= CLK_MHZ_10;
            endcase
        end
    end

    // ****************************************
    // bit-time clamp
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_time_out <= 8'h00;
        end else if (!cfg.enable) begin
            bit_time_out <= 8'h00;
        end else if (bit_time_in > cfg.upper) begin
            bit_time_out <= cfg.upper;
        end else if (bit_time_in < cfg.lower) begin
            bit_time_out <= cfg.lower;
        end else begin
            bit_time_out <= bit_time_in;
        end
    end

endmodule

// [hdl/swkcdr_regs.sv]
// What this block does
// - filter select 00/01/10 gives time constant 8/16/32, 11 means adaptive
// - adaptive: edges 2-3 bits apart use 32, 4-8 use 16, 9-10 use 8
// - control one bit 0 enables clock and data recovery
// - clock select 00/01/10/11 picks 80/40/20/10 MHz recovery clock
// - upper limit register clamps bit times above it
// - lower limit register clamps bit times below it
// - frame is sixteen bits: seven-bit address, mode bit, then data byte
// - data bits D0..D7 travel as frame bits 8..15
// - mode bit 0 reads the status byte and leaves it unchanged
// - mode bit 1 clears the addressed status byte, except the watchdog failure bits
// - status bits hold until cleared; only watchdog failure bits self-update
// - reserved control bits always read back zero
// - reset leaves control one at 0x04: constant 16, recovery off
// - reset limits are 0xa8 and 0x98; a soft reset reloads them
`timescale 1ns/1ns
module swkcdr_regs
    import swkcdr_pkg::*;
(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic                     soft_rst,
    // serial pins
    input  wire logic                     sclk,
    input  wire logic                     csn,
    input  wire logic                     sdi,
    output logic                          sdo,
    output logic                          sdo_oe,
    // status events and watchdog level
    input  wire logic [STAT_N-1:0][7:0]   stat_set,
    input  wire logic [7:0]               watchdog_failure_bits,
    // recovery datapath
    input  wire logic                     edge_valid,
    input  wire logic [3:0]               edge_dist,
    input  wire logic [7:0]               bit_time_in,
    output swkcdr_cfg_s                   cfg,
    output logic      [5:0]               time_const,
    output logic      [6:0]               clk_mhz,
    output logic      [7:0]               bit_time_out
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic       sclk_s1, sclk_s2, sclk_s3;
    logic       csn_s1, csn_s2, csn_s3;
    logic       sdi_s1, sdi_s2;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            csn_s1 <= 1'b1;
            csn_s2 <= 1'b1;
            csn_s3 <= 1'b1;
        end else begin
            csn_s1 <= csn;
            csn_s2 <= csn_s1;
            csn_s3 <= csn_s2;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end else begin
            sdi_s1 <= sdi;
            sdi_s2 <= sdi_s1;
        end
    end

    logic sclk_rise, sclk_fall, frame_start, frame_end;
    assign sclk_rise   = sclk_s2 & ~sclk_s3 & ~csn_s2;
    assign sclk_fall   = ~sclk_s2 & sclk_s3 & ~csn_s2;
    assign frame_start = ~csn_s2 & csn_s3;
    assign frame_end   = csn_s2 & ~csn_s3;

    // ****************************************
    // frame capture, first bit is frame bit 0
    // ****************************************
    logic [15:0] frame_reg;
    logic [4:0]  count_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_reg <= 5'd0;
        end else if (frame_start) begin
            count_reg <= 5'd0;
        end else if (sclk_rise && count_reg <= FRAME_BITS) begin
            // counts one past sixteen so a long frame is never taken
            count_reg <= count_reg + 5'd1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frame_reg <= 16'h0000;
        end else if (frame_start) begin
            frame_reg <= 16'h0000;
        end else if (sclk_rise && count_reg < FRAME_BITS) begin
            frame_reg[count_reg[3:0]] <= sdi_s2;
        end
    end

    logic [6:0] frame_addr;
    logic       frame_mode;
    logic [7:0] frame_data;
    logic       commit;
    assign frame_addr = frame_reg[6:0];
    assign frame_mode = frame_reg[MODE_POS];
    assign frame_data = frame_reg[DATA_POS +: 8];
    // short or long frames are dropped whole
    assign commit     = frame_end && count_reg == FRAME_BITS;

    // ****************************************
    // control registers
    // ****************************************
    logic wr_en;
    assign wr_en = commit & frame_mode;

    // ****************************************
    // address decode
    // ****************************************
    logic hit_ctrl_one;
    logic hit_ctrl_two;
    logic hit_upper;
    logic hit_lower;

    assign hit_ctrl_one = frame_addr == ADDR_CTRL_ONE;
    assign hit_ctrl_two = frame_addr == ADDR_CTRL_TWO;
    assign hit_upper    = frame_addr == ADDR_UPPER_LIM;
    assign hit_lower    = frame_addr == ADDR_LOWER_LIM;

    // ****************************************
    // configuration fields
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg.enable <= CTRL1_RST[CTRL1_EN_POS];
        end else if (soft_rst) begin
            cfg.enable <= CTRL1_RST[CTRL1_EN_POS];
        end else if (wr_en && hit_ctrl_one) begin
            cfg.enable <= frame_data[CTRL1_EN_POS];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg.filt <= CTRL1_RST[CTRL1_FILT_POS +: 2];
        end else if (soft_rst) begin
            cfg.filt <= CTRL1_RST[CTRL1_FILT_POS +: 2];
        end else if (wr_en && hit_ctrl_one) begin
            cfg.filt <= frame_data[CTRL1_FILT_POS +: 2];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg.clk_sel <= CTRL2_RST[CTRL2_CLK_POS +: 2];
        end else if (soft_rst) begin
            cfg.clk_sel <= CTRL2_RST[CTRL2_CLK_POS +: 2];
        end else if (wr_en && hit_ctrl_two) begin
            cfg.clk_sel <= frame_data[CTRL2_CLK_POS +: 2];
        end
    end

    // a soft reset reloads the limits to their reset values, like the control fields
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg.upper <= UPPER_RST;
        end else if (soft_rst) begin
            cfg.upper <= UPPER_RST;
        end else if (wr_en && hit_upper) begin
            cfg.upper <= frame_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg.lower <= LOWER_RST;
        end else if (soft_rst) begin
            cfg.lower <= LOWER_RST;
        end else if (wr_en && hit_lower) begin
            cfg.lower <= frame_data;
        end
    end

    // ****************************************
    // status registers
    // ****************************************
    logic [7:0] stat_reg [STAT_N];

    genvar gi;
    generate
        for (gi = 0; gi < STAT_N; gi++) begin : g_stat
            logic       clr;
            logic [7:0] kept;
            assign clr  = wr_en && frame_addr == STAT_ADDR[gi];
            assign kept = clr ? 8'h00 : stat_reg[gi];
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stat_reg[gi] <= STAT_RST;
                end else if (gi == WD_IDX) begin
                    // watchdog bits follow their source, the rest are sticky
                    stat_reg[gi] <= ((kept | stat_set[gi]) & ~WD_MASK)
                                    | (watchdog_failure_bits & WD_MASK);
                end else begin
                    // a new event in the clearing cycle survives
                    stat_reg[gi] <= kept | stat_set[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // read multiplexer
    // ****************************************
    logic [7:0] rd_data;

    always_comb begin
        rd_data = 8'h00;
        unique case (frame_addr)
            ADDR_CTRL_ONE:  rd_data = {4'h0, cfg.filt, 1'b0, cfg.enable};
            ADDR_CTRL_TWO:  rd_data = {6'h00, cfg.clk_sel};
            ADDR_UPPER_LIM: rd_data = cfg.upper;
            ADDR_LOWER_LIM: rd_data = cfg.lower;
            ADDR_FAMILY:    rd_data = FAMILY_ID;
            default: begin
                for (int i = 0; i < STAT_N; i++) begin
                    if (frame_addr == STAT_ADDR[i]) begin
                        rd_data = stat_reg[i];
                    end
                end
            end
        endcase
    end

    // ****************************************
    // serial output, changes on falling edge
    // ****************************************
    logic [7:0] out_reg;
    logic       load_byte;
    logic       shift_byte;

    // address is complete here, snapshot before any clear
    assign load_byte  = sclk_fall && count_reg == DATA_START;
    assign shift_byte = sclk_fall && count_reg > DATA_START;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sdo_oe <= 1'b0;
        end else if (frame_start) begin
            sdo_oe <= 1'b1;
        end else if (frame_end) begin
            sdo_oe <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_reg <= 8'h00;
        end else if (frame_start) begin
            out_reg <= 8'h00;
        end else if (load_byte) begin
            out_reg <= {1'b0, rd_data[7:1]};
        end else if (shift_byte) begin
            out_reg <= {1'b0, out_reg[7:1]};
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sdo <= 1'b0;
        end else if (frame_start || frame_end) begin
            sdo <= 1'b0;
        end else if (load_byte) begin
            sdo <= rd_data[0];
        end else if (shift_byte) begin
            sdo <= out_reg[0];
        end
    end

    // ****************************************
    // recovery configuration consumer
    // ****************************************
    swkcdr_shaper u_shaper (
        .clock        (clock),
        .rstn         (rstn),
        .cfg          (cfg),
        .edge_valid   (edge_valid),
        .edge_dist    (edge_dist),
        .bit_time_in  (bit_time_in),
        .time_const   (time_const),
        .clk_mhz      (clk_mhz),
        .bit_time_out (bit_time_out)
    );

endmodule

// [tb/swkcdr_regs_properties.sv]
`timescale 1ns/1ns
module swkcdr_regs_properties
    import swkcdr_pkg::*;
(
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic                   soft_rst,
    // serial pins
    input wire logic                   sclk,
    input wire logic                   csn,
    input wire logic                   sdi,
    input wire logic                   sdo,
    input wire logic                   sdo_oe,
    // status and datapath
    input wire logic [STAT_N-1:0][7:0] stat_set,
    input wire logic [7:0]             watchdog_failure_bits,
    input wire logic                   edge_valid,
    input wire logic [3:0]             edge_dist,
    input wire logic [7:0]             bit_time_in,
    input wire swkcdr_cfg_s            cfg,
    input wire logic [5:0]             time_const,
    input wire logic [6:0]             clk_mhz,
    input wire logic [7:0]             bit_time_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_fixed_filter: assert property (cfg.filt != FILT_ADAPT |=> time_const ==
        (($past(cfg.filt) == FILT_TC8) ? TC_8 : ($past(cfg.filt) == FILT_TC16) ? TC_16 : TC_32))
        else $error("fixed filter code gave wrong time constant");
    chk_adapt_near: assert property (
        cfg.filt == FILT_ADAPT && edge_valid && edge_dist inside {[4'h2:4'h3]} |=> time_const == TC_32)
        else $error("adaptive near edges did not pick 32");
    chk_adapt_mid: assert property (
        cfg.filt == FILT_ADAPT && edge_valid && edge_dist inside {[4'h4:4'h8]} |=> time_const == TC_16)
        else $error("adaptive middle edges did not pick 16");
    chk_adapt_far: assert property (
        cfg.filt == FILT_ADAPT && edge_valid && edge_dist inside {[4'h9:4'ha]} |=> time_const == TC_8)
        else $error("adaptive far edges did not pick 8");
    chk_adapt_hold: assert property (cfg.filt == FILT_ADAPT && !edge_valid |=> $stable(time_const))
        else $error("adaptive constant moved without an edge");
    chk_clock_select: assert property (1'b1 |=> clk_mhz == (($past(cfg.clk_sel) == 2'h0) ? CLK_MHZ_80 :
        ($past(cfg.clk_sel) == 2'h1) ? CLK_MHZ_40 : ($past(cfg.clk_sel) == 2'h2) ? CLK_MHZ_20 : CLK_MHZ_10))
        else $error("recovery clock does not follow select");
    chk_disabled_zero: assert property (!cfg.enable |=> bit_time_out == 8'h00)
        else $error("bit time passed while recovery disabled");
    chk_clamp_upper: assert property (cfg.enable && bit_time_in > cfg.upper |=> bit_time_out == $past(cfg.upper))
        else $error("long bit time not clamped to upper limit");
    chk_clamp_lower: assert property (cfg.enable && bit_time_in < cfg.lower |=> bit_time_out == $past(cfg.lower))
        else $error("short bit time not clamped to lower limit");
    chk_pass_through: assert property (cfg.enable && bit_time_in >= cfg.lower && bit_time_in <= cfg.upper
        |=> bit_time_out == $past(bit_time_in))
        else $error("in-range bit time altered");
    chk_reset_values: assert property ($rose(rstn) |-> cfg == {1'b0, FILT_TC16, 2'h0, UPPER_RST, LOWER_RST})
        else $error("configuration wrong after reset");
    chk_soft_reload: assert property (soft_rst |=> cfg == {1'b0, FILT_TC16, 2'h0, UPPER_RST, LOWER_RST})
        else $error("soft reset did not reload configuration");
    chk_idle_quiet: assert property (csn [*6] |-> !sdo_oe && !sdo)
        else $error("serial output active outside a frame");
    chk_frame_drive: assert property ((!csn) [*6] |-> sdo_oe)
        else $error("serial output not enabled inside a frame");
endmodule

bind swkcdr_regs swkcdr_regs_properties u_props (
    .clock(clock), .rstn(rstn), .soft_rst(soft_rst), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .stat_set(stat_set), .watchdog_failure_bits(watchdog_failure_bits),
    .edge_valid(edge_valid), .edge_dist(edge_dist), .bit_time_in(bit_time_in), .cfg(cfg),
    .time_const(time_const), .clk_mhz(clk_mhz), .bit_time_out(bit_time_out)
);

// [tb/swkcdr_spi_master.sv]
`timescale 1ns/1ns
module swkcdr_spi_master (
    // clock
    input  wire logic clock,
    // serial pins
    output logic      sclk,
    output logic      csn,
    output logic      sdi,
    input  wire logic sdo
);
    // half period well above the three-clock minimum of the synchronisers
    localparam int HALF = 6;

    initial begin
        sclk = 1'b0;
        csn  = 1'b1;
        sdi  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // nbits other than 16 gives a frame the device must drop
    task automatic xfer(input logic [6:0] addr, input logic mode, input logic [7:0] data,
                        input int nbits, output logic [7:0] rdata);
        logic [16:0] frame;
        frame = {1'b0, data, mode, addr};
        rdata = 8'h00;
        wait_clk(1);
        csn = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = frame[i];
            wait_clk(HALF);
            sclk = 1'b1;
            if (i >= 8 && i < 16) begin
                rdata[i-8] = sdo;
            end
            wait_clk(HALF);
            sclk = 1'b0;
        end
        wait_clk(HALF);
        csn = 1'b1;
        // released line shows no stale value
        sdi = ~sdi;
        wait_clk(8);
    endtask
endmodule

// [tb/swkcdr_regs_tb.sv]
`timescale 1ns/1ns
module swkcdr_regs_tb
    import swkcdr_pkg::*;
;
    logic                   clock;
    logic                   rstn;
    logic                   soft_rst;
    logic                   sclk;
    logic                   csn;
    logic                   sdi;
    logic                   sdo;
    logic                   sdo_oe;
    logic [STAT_N-1:0][7:0] stat_set;
    logic [7:0]             watchdog_failure_bits;
    logic                   edge_valid;
    logic [3:0]             edge_dist;
    logic [7:0]             bit_time_in;
    swkcdr_cfg_s            cfg;
    logic [5:0]             time_const;
    logic [6:0]             clk_mhz;
    logic [7:0]             bit_time_out;
    logic [7:0]             rd;
    logic [7:0]             v;
    logic [7:0]             wd;
    integer                 seed;
    int                     num_errors;
    int                     compares;
    int                     cycles;

    swkcdr_spi_master u_mst (.clock(clock), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo));

    swkcdr_regs u_dut (
        .clock(clock), .rstn(rstn), .soft_rst(soft_rst), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .stat_set(stat_set), .watchdog_failure_bits(watchdog_failure_bits),
        .edge_valid(edge_valid), .edge_dist(edge_dist), .bit_time_in(bit_time_in), .cfg(cfg),
        .time_const(time_const), .clk_mhz(clk_mhz), .bit_time_out(bit_time_out)
    );

    initial clock = 1'b0;
    always #20 clock = ~clock;

    // ****************************************
    // datapath stimulus and watchdog
    // ****************************************
    always @(posedge clock) begin
        #2;
        edge_valid  = 1'($random(seed));
        edge_dist   = 4'($random(seed));
        bit_time_in = 8'($random(seed));
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            close_out();
        end
    end

    // ****************************************
    // expectations and checks
    // ****************************************
    function automatic logic [7:0] ctrl_exp(input logic [6:0] a, input logic [7:0] d);
        return (a == ADDR_CTRL_ONE) ? (d & 8'h0d) : (a == ADDR_CTRL_TWO) ? (d & 8'h03) : d;
    endfunction

    function automatic logic [7:0] stat_exp(input int idx, input logic [7:0] s, input logic [7:0] w);
        return (idx == WD_IDX) ? ((s & ~WD_MASK) | (w & WD_MASK)) : s;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        u_mst.xfer(a, 1'b0, 8'($random(seed)), 16, rd);
        check(rd, e);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_mst.xfer(a, 1'b1, d, 16, rd);
    endtask

    task automatic close_out();
        $display("mismatches %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        seed = 32'hb912;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        rstn = 1'b0;
        soft_rst = 1'b0;
        edge_valid = 1'b0;
        edge_dist = 4'h0;
        bit_time_in = 8'h00;
        stat_set = '0;
        wd = 8'($random(seed));
        watchdog_failure_bits = wd;
        repeat (3) @(posedge clock);
        #2;
        rstn = 1'b1;
        rd_chk(ADDR_CTRL_ONE, CTRL1_RST);
        rd_chk(ADDR_CTRL_TWO, CTRL2_RST);
        rd_chk(ADDR_UPPER_LIM, UPPER_RST);
        rd_chk(ADDR_LOWER_LIM, LOWER_RST);
        rd_chk(ADDR_FAMILY, FAMILY_ID);
        rd_chk(7'h45, 8'h00);
        // every filter and clock code, bits 7:4 set at random
        for (int c = 0; c < 4; c++) begin
            v = 8'($random(seed));
            v[3:2] = 2'(c);
            v[1:0] = 2'(c);
            wr(ADDR_CTRL_ONE, v);
            rd_chk(ADDR_CTRL_ONE, ctrl_exp(ADDR_CTRL_ONE, v));
            check({6'h00, cfg.filt}, 8'(c));
            wr(ADDR_CTRL_TWO, v);
            rd_chk(ADDR_CTRL_TWO, ctrl_exp(ADDR_CTRL_TWO, v));
        end
        // upper kept above lower so the two clamps never conflict
        v = 8'($random(seed)) | 8'h80;
        wr(ADDR_UPPER_LIM, v);
        rd_chk(ADDR_UPPER_LIM, v);
        v = 8'($random(seed)) & 8'h7f;
        wr(ADDR_LOWER_LIM, v);
        rd_chk(ADDR_LOWER_LIM, v);
        u_mst.xfer(ADDR_LOWER_LIM, 1'b1, ~v, 15, rd);
        rd_chk(ADDR_LOWER_LIM, v);
        u_mst.xfer(ADDR_LOWER_LIM, 1'b1, ~v, 17, rd);
        rd_chk(ADDR_LOWER_LIM, v);
        // status bytes: set, read twice, clear, read
        for (int i = 0; i < STAT_N; i++) begin
            v = 8'($random(seed)) | 8'h01;
            @(posedge clock);
            #2;
            stat_set[i] = v;
            @(posedge clock);
            #2;
            stat_set[i] = 8'h00;
            rd_chk(STAT_ADDR[i], stat_exp(i, v, wd));
            rd_chk(STAT_ADDR[i], stat_exp(i, v, wd));
            wr(STAT_ADDR[i], 8'($random(seed)));
            rd_chk(STAT_ADDR[i], stat_exp(i, 8'h00, wd));
        end
        wd = ~wd;
        watchdog_failure_bits = wd;
        rd_chk(STAT_ADDR[WD_IDX], wd & WD_MASK);
        soft_rst = 1'b1;
        @(posedge clock);
        #2;
        soft_rst = 1'b0;
        rd_chk(ADDR_UPPER_LIM, UPPER_RST);
        rd_chk(ADDR_CTRL_ONE, CTRL1_RST);
        // 80 MHz with the recommended limits suits 500 kbit/s, no overflow
        rd_chk(ADDR_LOWER_LIM, LOWER_RST);
        rd_chk(ADDR_CTRL_TWO, CTRL2_RST);
        close_out();
    end
endmodule
